// [rtl/hpp_defines.svh]
// Constants for the host parallel port, both ends
// How it works
// (R1) Data bus stays input except host reads
// (R2) Strobe with direction high drives slot data
// (R3) Write byte captured as strobe deasserts
// (R4) Host drives select and direction each access
// (R5) Pins fall back to fifteen GPIO bits
// (R6) Reset leaves every pin an undriven input
// (R7) Request open-drain, push-pull as GPIO
// (R8) Acknowledge completes DMA or fetches vector
// (R9) Host writes vector only while command clear
// (R10) Host rereads status until two reads agree on both flags
// (R11) Select decodes into eight register slots
`ifndef HPP_DEFINES_SVH
`define HPP_DEFINES_SVH
`define HPP_NPIN 15
`define HPP_DW 8
`define HPP_SW 3
`define HPP_HVW 7
`define HPP_SLOTS 8
`define HPP_D_LO 0
`define HPP_SEL_LO 8
`define HPP_DIR 11
`define HPP_STB 12
`define HPP_REQ 13
`define HPP_ACK 14
`define HPP_SLOT_DMA 3'h0
`define HPP_SLOT_HV 3'h1
`define HPP_SLOT_IVEC 3'h2
`define HPP_SLOT_STAT 3'h7
`define HPP_HC_BIT 7
`define HPP_FLAG_HI 7
`define HPP_FLAG_LO 6
`define HPP_FIFO_W 11
`define HPP_FIFO_D 8
`define HPP_STB_CYC 3'h4
`define HPP_PINS_OFF 15'h7FFF
`define HPP_PINS_ZERO 15'h0000
`define HPP_DRV_CTL 15'h20FF
`define HPP_BYTE_ONES 8'hFF
`define HPP_BYTE_ZERO 8'h00
`define HPP_CNT_ONE 3'h1
`endif

// [rtl/hpp_pkg.sv]
// Shared types of the host parallel port
`include "hpp_defines.svh"
package hpp_pkg;
	typedef logic [`HPP_NPIN-1:0] hpp_pins_t;
	typedef logic [`HPP_DW-1:0] hpp_byte_t;
	typedef logic [`HPP_SW-1:0] hpp_sel_t;
	typedef struct packed
	{
		hpp_sel_t sel;
		hpp_byte_t data;
	} hpp_rx_s;
	typedef enum logic [1:0] {HST_IDLE, HST_ACT, HST_GAP} hpp_hst_e;
endpackage

// [rtl/hpp_if.sv]
// Pin bundle between the port and its host, wired-AND with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface hpp_if;
	hpp_pkg::hpp_pins_t dev_o;
	hpp_pkg::hpp_pins_t dev_oe_n;
	hpp_pkg::hpp_pins_t host_o;
	hpp_pkg::hpp_pins_t host_oe_n;
	hpp_pkg::hpp_pins_t pin;
	// An undriven pin floats high, as the pull-ups on the board make it
	assign pin = (dev_oe_n | dev_o) & (host_oe_n | host_o);
	modport dev (input pin, output dev_o, output dev_oe_n);
	modport host (input pin, output host_o, output host_oe_n);
endinterface
`default_nettype wire

// [rtl/hpp_fifo.sv]
// Shift-register FIFO with registered head and full flag
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defines.svh"
module hpp_fifo #(parameter int W = `HPP_FIFO_W, parameter int D = `HPP_FIFO_D)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [D];
	logic [D-1:0] vld_r;
	logic [W-1:0] up_d [D];
	logic [D-1:0] up_v;
	logic [D-1:0] below_v;
	logic [D-1:0] sh_v;
	logic pop;
	logic push;
	assign pop = out_ready & vld_r[0];
	assign push = in_valid & in_ready;
	assign in_ready = ~vld_r[D-1];
	assign out_valid = vld_r[0];
	assign out_data = mem_r[0];
	genvar i;
	generate
		for (i = 0; i < D; i++)
		begin : g_ent
			logic [W-1:0] d_nxt;
			logic v_nxt;
			if (i == D-1)
			begin : g_top
				assign up_d[i] = '0;
				assign up_v[i] = 1'b0;
			end
			else
			begin : g_mid
				assign up_d[i] = mem_r[i+1];
				assign up_v[i] = vld_r[i+1];
			end
			if (i == 0)
			begin : g_bot
				assign below_v[i] = 1'b1;
			end
			else
			begin : g_up
				assign below_v[i] = sh_v[i-1];
			end
			assign sh_v[i] = pop ? up_v[i] : vld_r[i];
			always_comb
			begin
				d_nxt = pop ? up_d[i] : mem_r[i];
				v_nxt = sh_v[i];
				// New word lands in the lowest slot left empty after the shift
				if (push && !sh_v[i] && below_v[i])
				begin
					d_nxt = in_data;
					v_nxt = 1'b1;
				end
			end
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					mem_r[i] <= '0;
					vld_r[i] <= 1'b0;
				end
				else
				begin
					mem_r[i] <= d_nxt;
					vld_r[i] <= v_nxt;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [rtl/hpp_dev.sv]
// Device end of the host parallel port: slots, GPIO fallback, receive FIFO
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defines.svh"
module hpp_dev
(
	input wire logic MCLK,
	input wire logic RSTN,
	hpp_if.dev LINK,
	input wire logic HOST_EN,
	input wire logic ACK_MODE,
	input wire logic [`HPP_NPIN-1:0] GPIO_DIR,
	input wire logic [`HPP_NPIN-1:0] GPIO_OUT,
	output logic [`HPP_NPIN-1:0] GPIO_IN,
	input wire logic SLOT_WE,
	input wire logic [`HPP_SW-1:0] SLOT_ADDR,
	input wire logic [`HPP_DW-1:0] SLOT_DATA,
	input wire logic [1:0] FLAGS,
	input wire logic REQ,
	input wire logic CMD_CLR,
	output logic CMD_BIT,
	output logic [`HPP_HVW-1:0] HOST_VEC,
	output logic RX_VALID,
	input wire logic RX_READY,
	output logic [`HPP_SW-1:0] RX_SEL,
	output logic [`HPP_DW-1:0] RX_DATA,
	output logic OVERRUN,
	output logic ACK_SEEN
);
	logic mode_r, mode_nxt;
	logic ackm_r, ackm_nxt;
	hpp_pkg::hpp_pins_t gdir_r, gdir_nxt;
	hpp_pkg::hpp_pins_t gout_r, gout_nxt;
	hpp_pkg::hpp_pins_t gin_r, gin_nxt;
	hpp_pkg::hpp_pins_t o_r, o_nxt;
	hpp_pkg::hpp_pins_t oen_r, oen_nxt;
	hpp_pkg::hpp_byte_t slot_r [`HPP_SLOTS];
	hpp_pkg::hpp_byte_t slot_nxt [`HPP_SLOTS];
	logic [1:0] flag_r, flag_nxt;
	logic req_r, req_nxt;
	logic acc_prev_r, acc_prev_nxt;
	logic dir_prev_r, dir_prev_nxt;
	hpp_pkg::hpp_sel_t sel_prev_r, sel_prev_nxt;
	hpp_pkg::hpp_byte_t dat_prev_r, dat_prev_nxt;
	logic ackp_r, ackp_nxt;
	logic hc_r, hc_nxt;
	logic [`HPP_HVW-1:0] hv_r, hv_nxt;
	logic ovr_r, ovr_nxt;
	logic seen_r, seen_nxt;
	logic stb;
	logic ack;
	logic dir;
	logic dma;
	logic vec;
	logic acc;
	logic wr_done;
	logic fifo_ready;
	logic push;
	hpp_pkg::hpp_sel_t sel;
	hpp_pkg::hpp_sel_t asel;
	hpp_pkg::hpp_byte_t rdata;
	hpp_pkg::hpp_rx_s rx_in;
	hpp_pkg::hpp_rx_s rx_out;

	// Pins are sampled straight; the host is synchronous to MCLK
	assign stb = ~LINK.pin[`HPP_STB];
	assign ack = ~LINK.pin[`HPP_ACK];
	assign dir = LINK.pin[`HPP_DIR];
	assign sel = LINK.pin[`HPP_SEL_LO +: `HPP_SW];
	assign dma = mode_r & ~ackm_r & ack; // R8
	assign vec = mode_r & ackm_r & ack; // R8
	assign acc = mode_r & (stb | dma);
	assign asel = stb ? sel : `HPP_SLOT_DMA;
	// Capture uses the byte of the last strobed cycle, held past the edge
	assign wr_done = acc_prev_r & ~acc & ~dir_prev_r; // R3
	assign push = wr_done && (sel_prev_r != `HPP_SLOT_HV);
	assign rx_in = '{sel: sel_prev_r, data: dat_prev_r};

	always_comb
	begin
		case (asel) // R11
			`HPP_SLOT_HV: rdata = {hc_r, hv_r};
			`HPP_SLOT_STAT: rdata = {flag_r, 4'h0, hc_r, ~fifo_ready};
			default: rdata = slot_r[asel];
		endcase
	end

	always_comb
	begin
		mode_nxt = HOST_EN;
		ackm_nxt = ACK_MODE;
		gdir_nxt = GPIO_DIR;
		gout_nxt = GPIO_OUT;
		gin_nxt = LINK.pin;
		flag_nxt = FLAGS;
		req_nxt = REQ;
		slot_nxt = slot_r;
		if (SLOT_WE)
			slot_nxt[SLOT_ADDR] = SLOT_DATA;
		acc_prev_nxt = acc;
		dir_prev_nxt = dir;
		sel_prev_nxt = asel;
		dat_prev_nxt = LINK.pin[`HPP_D_LO +: `HPP_DW];
		ackp_nxt = ack;
		seen_nxt = mode_r & ack & ~ackp_r;
		// A full FIFO drops the byte; the host sees the full bit in status
		ovr_nxt = push & ~fifo_ready;
		hv_nxt = hv_r;
		hc_nxt = hc_r;
		if (CMD_CLR)
			hc_nxt = 1'b0;
		// Setting wins over a clear in the same cycle
		if (wr_done && sel_prev_r == `HPP_SLOT_HV) // R11
		begin
			hv_nxt = dat_prev_r[`HPP_HVW-1:0];
			hc_nxt = hc_nxt | dat_prev_r[`HPP_HC_BIT];
		end
		if (mode_r)
		begin
			o_nxt = `HPP_PINS_OFF;
			oen_nxt = `HPP_PINS_OFF;
			if ((acc & dir) | vec) // R1
			begin
				oen_nxt[`HPP_D_LO +: `HPP_DW] = `HPP_BYTE_ZERO; // R2
				o_nxt[`HPP_D_LO +: `HPP_DW] = vec ? slot_r[`HPP_SLOT_IVEC] : rdata; // R8
			end
			o_nxt[`HPP_REQ] = 1'b0; // R7
			oen_nxt[`HPP_REQ] = ~req_r; // R7
		end
		else
		begin
			o_nxt = gout_r; // R5
			oen_nxt = ~gdir_r; // R5
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			mode_r <= 1'b0;
			ackm_r <= 1'b0;
			gdir_r <= `HPP_PINS_ZERO; // R6
			gout_r <= `HPP_PINS_ZERO;
			gin_r <= `HPP_PINS_ZERO;
			o_r <= `HPP_PINS_OFF;
			oen_r <= `HPP_PINS_OFF; // R6
			for (int k = 0; k < `HPP_SLOTS; k++)
				slot_r[k] <= `HPP_BYTE_ZERO;
			flag_r <= 2'h0;
			req_r <= 1'b0;
			acc_prev_r <= 1'b0;
			dir_prev_r <= 1'b0;
			sel_prev_r <= `HPP_SLOT_DMA;
			dat_prev_r <= `HPP_BYTE_ZERO;
			ackp_r <= 1'b0;
			hc_r <= 1'b0;
			hv_r <= '0;
			ovr_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			ackm_r <= ackm_nxt;
			gdir_r <= gdir_nxt;
			gout_r <= gout_nxt;
			gin_r <= gin_nxt;
			o_r <= o_nxt;
			oen_r <= oen_nxt;
			slot_r <= slot_nxt;
			flag_r <= flag_nxt;
			req_r <= req_nxt;
			acc_prev_r <= acc_prev_nxt;
			dir_prev_r <= dir_prev_nxt;
			sel_prev_r <= sel_prev_nxt;
			dat_prev_r <= dat_prev_nxt;
			ackp_r <= ackp_nxt;
			hc_r <= hc_nxt;
			hv_r <= hv_nxt;
			ovr_r <= ovr_nxt;
			seen_r <= seen_nxt;
		end
	end

	hpp_fifo #(.W(`HPP_FIFO_W), .D(`HPP_FIFO_D)) u_rx
	(
		.clk(MCLK),
		.rst_n(RSTN),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(rx_in),
		.out_valid(RX_VALID),
		.out_ready(RX_READY),
		.out_data(rx_out)
	);

	assign RX_SEL = rx_out.sel;
	assign RX_DATA = rx_out.data;
	assign LINK.dev_o = o_r;
	assign LINK.dev_oe_n = oen_r;
	assign GPIO_IN = gin_r;
	assign CMD_BIT = hc_r;
	assign HOST_VEC = hv_r;
	assign OVERRUN = ovr_r;
	assign ACK_SEEN = seen_r;
endmodule
`default_nettype wire

// [rtl/hpp_host.sv]
// Host end of the host parallel port: strobe or acknowledge accesses, repeated for status reads and vector writes
`timescale 1ns/1ps
`default_nettype none
`include "hpp_defines.svh"
module hpp_host
(
	input wire logic MCLK,
	input wire logic RSTN,
	hpp_if.host LINK,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic REQ_ACK,
	input wire logic [`HPP_SW-1:0] REQ_SEL,
	input wire logic [`HPP_DW-1:0] REQ_DATA,
	output logic RSP_VALID,
	output logic [`HPP_DW-1:0] RSP_DATA,
	output logic RSP_REFUSED,
	output logic SRV_REQ
);
	hpp_pkg::hpp_hst_e st_r, st_nxt;
	logic wr_r, wr_nxt;
	logic ak_r, ak_nxt;
	logic chk_r, chk_nxt;
	logic conf_r, conf_nxt;
	hpp_pkg::hpp_sel_t sel_r, sel_nxt;
	hpp_pkg::hpp_byte_t dat_r, dat_nxt;
	hpp_pkg::hpp_byte_t rd_r, rd_nxt;
	hpp_pkg::hpp_byte_t prev_r, prev_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	hpp_pkg::hpp_pins_t o_r, o_nxt;
	hpp_pkg::hpp_pins_t oen_r, oen_nxt;
	logic rdy_r, rdy_nxt;
	logic rv_r, rv_nxt;
	logic ref_r, ref_nxt;
	hpp_pkg::hpp_byte_t rdat_r, rdat_nxt;
	logic srv_r, srv_nxt;
	logic done;

	always_comb
	begin
		st_nxt = st_r;
		wr_nxt = wr_r;
		ak_nxt = ak_r;
		chk_nxt = chk_r;
		conf_nxt = conf_r;
		sel_nxt = sel_r;
		dat_nxt = dat_r;
		rd_nxt = rd_r;
		prev_nxt = prev_r;
		cnt_nxt = cnt_r;
		rv_nxt = 1'b0;
		ref_nxt = 1'b0;
		rdat_nxt = rdat_r;
		done = 1'b0;
		srv_nxt = ~LINK.pin[`HPP_REQ];
		case (st_r)
			hpp_pkg::HST_IDLE:
			begin
				if (REQ_VALID && rdy_r)
				begin
					wr_nxt = REQ_WRITE;
					ak_nxt = REQ_ACK;
					sel_nxt = REQ_SEL;
					dat_nxt = REQ_DATA;
					// Vector write first reads the command bit back
					chk_nxt = REQ_WRITE && !REQ_ACK && REQ_SEL == `HPP_SLOT_HV; // R9
					conf_nxt = 1'b0;
					cnt_nxt = 3'h0;
					st_nxt = hpp_pkg::HST_ACT;
				end
			end
			hpp_pkg::HST_ACT:
			begin
				cnt_nxt = cnt_r + `HPP_CNT_ONE;
				if (cnt_r == `HPP_STB_CYC - `HPP_CNT_ONE)
				begin
					rd_nxt = LINK.pin[`HPP_D_LO +: `HPP_DW];
					st_nxt = hpp_pkg::HST_GAP;
				end
			end
			hpp_pkg::HST_GAP:
			begin
				cnt_nxt = 3'h0;
				if (chk_r)
				begin
					if (rd_r[`HPP_HC_BIT]) // R9
					begin
						ref_nxt = 1'b1;
						done = 1'b1;
					end
					else
					begin
						chk_nxt = 1'b0;
						st_nxt = hpp_pkg::HST_ACT;
					end
				end
				else if (!wr_r && !ak_r && sel_r == `HPP_SLOT_STAT)
				begin
					// Flags may pass through a mixed code while both change
					conf_nxt = 1'b1;
					prev_nxt = rd_r;
					if (conf_r && rd_r[`HPP_FLAG_HI:`HPP_FLAG_LO] == prev_r[`HPP_FLAG_HI:`HPP_FLAG_LO]) // R10
						done = 1'b1;
					else
						st_nxt = hpp_pkg::HST_ACT;
				end
				else
					done = 1'b1;
				if (done)
				begin
					rv_nxt = 1'b1;
					rdat_nxt = rd_r;
					st_nxt = hpp_pkg::HST_IDLE;
				end
			end
			default: st_nxt = hpp_pkg::HST_IDLE;
		endcase
		rdy_nxt = st_nxt == hpp_pkg::HST_IDLE;
		o_nxt = `HPP_PINS_OFF;
		oen_nxt = `HPP_DRV_CTL;
		if (st_nxt != hpp_pkg::HST_IDLE)
		begin
			o_nxt[`HPP_SEL_LO +: `HPP_SW] = chk_nxt ? `HPP_SLOT_HV : sel_nxt; // R4
			o_nxt[`HPP_DIR] = ~(wr_nxt & ~chk_nxt); // R4
			if (wr_nxt && !chk_nxt) // R3
			begin
				o_nxt[`HPP_D_LO +: `HPP_DW] = dat_nxt;
				oen_nxt[`HPP_D_LO +: `HPP_DW] = `HPP_BYTE_ZERO;
			end
		end
		if (st_nxt == hpp_pkg::HST_ACT)
		begin
			if (ak_nxt)
				o_nxt[`HPP_ACK] = 1'b0;
			else
				o_nxt[`HPP_STB] = 1'b0;
		end
		oen_nxt[`HPP_REQ] = 1'b1;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			st_r <= hpp_pkg::HST_IDLE;
			wr_r <= 1'b0;
			ak_r <= 1'b0;
			chk_r <= 1'b0;
			conf_r <= 1'b0;
			sel_r <= `HPP_SLOT_DMA;
			dat_r <= `HPP_BYTE_ZERO;
			rd_r <= `HPP_BYTE_ZERO;
			prev_r <= `HPP_BYTE_ZERO;
			cnt_r <= 3'h0;
			o_r <= `HPP_PINS_OFF;
			oen_r <= `HPP_PINS_OFF;
			rdy_r <= 1'b0;
			rv_r <= 1'b0;
			ref_r <= 1'b0;
			rdat_r <= `HPP_BYTE_ZERO;
			srv_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			wr_r <= wr_nxt;
			ak_r <= ak_nxt;
			chk_r <= chk_nxt;
			conf_r <= conf_nxt;
			sel_r <= sel_nxt;
			dat_r <= dat_nxt;
			rd_r <= rd_nxt;
			prev_r <= prev_nxt;
			cnt_r <= cnt_nxt;
			o_r <= o_nxt;
			oen_r <= oen_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			ref_r <= ref_nxt;
			rdat_r <= rdat_nxt;
			srv_r <= srv_nxt;
		end
	end

	assign LINK.host_o = o_r;
	assign LINK.host_oe_n = oen_r;
	assign REQ_READY = rdy_r;
	assign RSP_VALID = rv_r;
	assign RSP_DATA = rdat_r;
	assign RSP_REFUSED = ref_r;
	assign SRV_REQ = srv_r;
endmodule
`default_nettype wire

// [testbench/hpp_assertions.sv]
// Pin checks between the port and its host
`timescale 1ns/1ps
`default_nettype none
module hpp_assertions
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire hpp_pkg::hpp_pins_t dev_o,
	input wire hpp_pkg::hpp_pins_t dev_oe_n,
	input wire hpp_pkg::hpp_pins_t host_o,
	input wire hpp_pkg::hpp_pins_t host_oe_n,
	input wire hpp_pkg::hpp_pins_t pin
);
	logic rst_r;
	always_ff @(posedge MCLK)
	begin
		rst_r <= !RSTN;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	chk_reset_quiet: assert property (rst_r |-> &dev_oe_n && &host_oe_n)
		else $error("pin driven straight after reset");
	chk_data_cause: assert property (dev_oe_n[7:0] != 8'hFF |->
		(!$past(pin[12]) && $past(pin[11])) || !$past(pin[14]))
		else $error("data bus driven without a read");
	chk_no_fight: assert property ((dev_oe_n[7:0] | host_oe_n[7:0]) == 8'hFF)
		else $error("both ends drive the data bus");
	chk_read_window: assert property ($fell(pin[12]) && pin[11] |=>
		(dev_oe_n[7:0] == 8'h00) [*4] ##1 dev_oe_n[7:0] == 8'hFF)
		else $error("read data window wrong");
	chk_strobe_len: assert property ($fell(pin[12]) |-> !pin[12] [*4] ##1 pin[12])
		else $error("strobe length wrong");
	chk_data_release: assert property ($rose(pin[12]) |=> dev_oe_n[7:0] == 8'hFF)
		else $error("data bus still driven after strobe release");
	chk_sel_hold: assert property (!pin[12] && !$past(pin[12]) |->
		$stable(pin[11:8]) && (pin[11] || $stable(pin[7:0])))
		else $error("select or write data moved under strobe");
	chk_host_dir: assert property (host_oe_n[7:0] != 8'hFF |-> !host_o[11] && !host_oe_n[11])
		else $error("host drives data while not writing");
	// Unused here: only the wired level matters
	wire logic [14:0] unused_o = dev_o;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench: port end facing host end
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {logic wr, ack, am; logic [2:0] sel; logic [7:0] d; logic [1:0] fl;
		logic [7:0] exp;} hpp_row_s;
	logic MCLK = 1'h0, RSTN = 1'h0, host_en = 1'h0, ack_mode = 1'h0, slot_we = 1'h0;
	logic req = 1'h0, cmd_clr = 1'h0, rx_ready = 1'h0, q_valid = 1'h0, q_write = 1'h0;
	logic q_ack = 1'h0, cmd_bit, rx_valid, overrun, ack_seen, q_ready, rsp_valid, rsp_ref, srv;
	hpp_pkg::hpp_pins_t gpio_dir = 15'h0000, gpio_out = 15'h0000, gpio_in;
	hpp_pkg::hpp_sel_t slot_addr = 3'h0, q_sel = 3'h0, rx_sel;
	hpp_pkg::hpp_byte_t slot_data = 8'h00, q_data = 8'h00, rx_data, rsp_data;
	hpp_pkg::hpp_byte_t ovr_cnt = 8'h00, ack_cnt = 8'h00;
	logic [1:0] flags = 2'h0;
	logic [6:0] host_vec;
	int num_errors = 0, n_tests = 0;
	hpp_pkg::hpp_byte_t slots [7] = '{8'h11, 8'h00, 8'h2E, 8'h5A, 8'hC3, 8'h69, 8'h96};
	// Ack rows: mode 1 fetches the vector slot, mode 0 is a DMA cycle on slot 0
	hpp_row_s rows [14] = '{'{0,0,0,3,0,0,8'h5A}, '{0,0,0,4,0,0,8'hC3}, '{0,0,0,5,0,0,8'h69},
		'{0,0,0,6,0,0,8'h96}, '{0,0,0,0,0,0,8'h11}, '{1,0,0,4,8'hA5,0,0}, '{1,0,0,6,8'h3C,0,0},
		'{0,0,0,7,0,0,8'h00}, '{0,0,0,7,0,1,8'h40}, '{0,0,0,7,0,2,8'h80}, '{0,0,0,7,0,3,8'hC0},
		'{0,1,1,5,0,0,8'h2E}, '{0,1,0,5,0,0,8'h11}, '{1,1,0,5,8'h77,0,0}};
	always #20 MCLK = ~MCLK;
	always @(posedge MCLK)
	begin
		if (overrun === 1'h1) ovr_cnt++;
		if (ack_seen === 1'h1) ack_cnt++;
	end
	hpp_if link();
	hpp_dev i_hpp_dev (.MCLK(MCLK), .RSTN(RSTN), .LINK(link), .HOST_EN(host_en),
		.ACK_MODE(ack_mode), .GPIO_DIR(gpio_dir), .GPIO_OUT(gpio_out), .GPIO_IN(gpio_in),
		.SLOT_WE(slot_we), .SLOT_ADDR(slot_addr), .SLOT_DATA(slot_data), .FLAGS(flags),
		.REQ(req), .CMD_CLR(cmd_clr), .CMD_BIT(cmd_bit), .HOST_VEC(host_vec),
		.RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_SEL(rx_sel), .RX_DATA(rx_data),
		.OVERRUN(overrun), .ACK_SEEN(ack_seen));
	hpp_host i_hpp_host (.MCLK(MCLK), .RSTN(RSTN), .LINK(link), .REQ_VALID(q_valid),
		.REQ_READY(q_ready), .REQ_WRITE(q_write), .REQ_ACK(q_ack), .REQ_SEL(q_sel),
		.REQ_DATA(q_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
		.RSP_REFUSED(rsp_ref), .SRV_REQ(srv));
	hpp_assertions i_hpp_assertions (.MCLK(MCLK), .RSTN(RSTN), .dev_o(link.dev_o),
		.dev_oe_n(link.dev_oe_n), .host_o(link.host_o), .host_oe_n(link.host_oe_n),
		.pin(link.pin));
	task automatic close_out();
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic step();
		@(posedge MCLK);
		#1;
	endtask
	task automatic bound(input int n);
		if (n >= 100)
		begin
			num_errors++;
			$display("CHECK FAILED %0t wait ran out", $time);
			close_out();
		end
	endtask
	task automatic chk_byte(input hpp_pkg::hpp_byte_t got, input hpp_pkg::hpp_byte_t exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pins(input hpp_pkg::hpp_pins_t got, input hpp_pkg::hpp_pins_t exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t pins %h expected %h", $time, got, exp);
		end
	endtask
	// Request is held until the ready seen here is sampled by the next edge
	task automatic access(input logic wr, input logic ak, input hpp_pkg::hpp_sel_t s,
		input hpp_pkg::hpp_byte_t d);
		int n;
		q_valid = 1'h1;
		q_write = wr;
		q_ack = ak;
		q_sel = s;
		q_data = d;
		for (n = 0; n < 100 && q_ready !== 1'h1; n++) step();
		bound(n);
		step();
		q_valid = 1'h0;
		for (n = 0; n < 100 && rsp_valid !== 1'h1; n++) step();
		bound(n);
	endtask
	task automatic pop(input hpp_pkg::hpp_sel_t s, input hpp_pkg::hpp_byte_t d);
		int n;
		for (n = 0; n < 100 && rx_valid !== 1'h1; n++) step();
		bound(n);
		chk_byte({5'h00, rx_sel}, {5'h00, s});
		chk_byte(rx_data, d);
		rx_ready = 1'h1;
		step();
		rx_ready = 1'h0;
	endtask
	task automatic wait_srv(input logic v);
		int n;
		for (n = 0; n < 100 && srv !== v; n++) step();
		bound(n);
		step();
	endtask
	initial
	begin
		repeat (10) @(posedge MCLK);
		#1;
		chk_pins(link.dev_oe_n, 15'h7FFF);
		chk_pins(link.pin, 15'h7FFF);
		RSTN = 1'h1;
		host_en = 1'h1;
		step();
		slot_we = 1'h1;
		for (int i = 0; i < 7; i++)
		begin
			slot_addr = i[2:0];
			slot_data = slots[i];
			step();
		end
		slot_we = 1'h0;
		foreach (rows[i])
		begin
			ack_mode = rows[i].am;
			flags = rows[i].fl;
			access(rows[i].wr, rows[i].ack, rows[i].sel, rows[i].d);
			chk_byte({7'h00, rsp_ref}, 8'h00);
			if (rows[i].wr)
				pop(rows[i].ack ? 3'h0 : rows[i].sel, rows[i].d);
			else
				chk_byte(rsp_data, rows[i].exp);
		end
		chk_byte(ack_cnt, 8'h03);
		flags = 2'h0;
		for (int i = 0; i < 8; i++) access(1'h1, 1'h0, 3'h5, 8'hE0 + i[7:0]);
		access(1'h0, 1'h0, 3'h7, 8'h00);
		chk_byte(rsp_data, 8'h01);
		access(1'h1, 1'h0, 3'h5, 8'h55);
		step();
		chk_byte(ovr_cnt, 8'h01);
		for (int i = 0; i < 8; i++) pop(3'h5, 8'hE0 + i[7:0]);
		chk_byte({7'h00, rx_valid}, 8'h00);
		access(1'h1, 1'h0, 3'h1, 8'h85);
		step();
		chk_byte({host_vec, cmd_bit}, 8'h0B);
		access(1'h1, 1'h0, 3'h1, 8'h02);
		chk_byte({7'h00, rsp_ref}, 8'h01);
		chk_byte({1'h0, host_vec}, 8'h05);
		cmd_clr = 1'h1;
		step();
		cmd_clr = 1'h0;
		access(1'h1, 1'h0, 3'h1, 8'h02);
		access(1'h0, 1'h0, 3'h1, 8'h00);
		chk_byte(rsp_data, 8'h02);
		req = 1'h1;
		wait_srv(1'h1);
		chk_pins(link.dev_oe_n & 15'h2000 | link.dev_o & 15'h2000, 15'h0000);
		req = 1'h0;
		wait_srv(1'h0);
		chk_pins(link.dev_oe_n & 15'h2000, 15'h2000);
		host_en = 1'h0;
		gpio_dir = 15'h2000;
		gpio_out = 15'h2000;
		repeat (3) step();
		chk_pins(link.dev_oe_n, 15'h5FFF);
		chk_pins(link.dev_o & 15'h2000, 15'h2000);
		chk_pins(gpio_in & 15'h70FF, 15'h70FF);
		gpio_out = 15'h0000;
		wait_srv(1'h1);
		chk_pins(gpio_in & 15'h2000, 15'h0000);
		gpio_dir = 15'h0000;
		host_en = 1'h1;
		repeat (3) step();
		access(1'h1, 1'h0, 3'h1, 8'h81);
		RSTN = 1'h0;
		step();
		step();
		chk_byte({6'h00, cmd_bit, rx_valid}, 8'h00);
		chk_pins(link.dev_oe_n, 15'h7FFF);
		RSTN = 1'h1;
		step();
		close_out();
	end
endmodule
`default_nettype wire
